// *** logic/system_reset_controller.sv ***
// How it works
// - power-on detection resets all logic, test access port included.
// - reset pin resets core and peripherals but not the test port.
// - internal reset held until every reset source goes inactive, then for the 8-cycle release stretch, then boot.
// - power-on source only counts before the first release, never after.
// - supply droop detection disabled out of reset until software enables.
// - supply droop raises an interrupt or a reset, per configuration.
// - droop resets only when the droop reset enable bit is set.
// - droop reset has pin scope, held while the droop persists.
// - droop reset recorded in the cause record.
// - writing a peripheral bit one then zero resets that peripheral.
// - peripheral reset bits follow clock gating bit positions.
// - peripheral software reset drives every clock domain of that unit.
// - system reset request bit resets core and peripherals but not the test port.
// - watchdog interrupts on first time-out, resets on second.
// - after first time-out the 32-bit counter reloads and continues.
// - zero again with interrupt uncleared and reset enabled gives reset.
// - watchdog reset asserts internal reset then releases into boot.
// - cause bits sticky; power-on clears others and sets its own.
module system_reset_controller (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic power_on_detect,
    input wire logic reset_pin_n,
    input wire logic supply_droop_detect,
    input wire logic droop_detect_enable,
    input wire logic droop_reset_enable,
    input wire logic system_reset_request_bit,
    input wire logic [31:0] peripheral_reset_control_regs,
    input wire logic wdog_enable,
    input wire logic wdog_reset_enable,
    input wire logic [31:0] watchdog_reload_value_reg,
    input wire logic wdog_service,
    input wire logic wdog_int_clear,
    output logic core_reset,
    output logic periph_reset,
    output logic tap_reset,
    output logic [31:0] periph_domain_reset_0,
    output logic [31:0] periph_domain_reset_1,
    output logic droop_interrupt,
    output logic wdog_interrupt,
    output logic [4:0] reset_cause_record,
    output logic boot_fetch
);
    logic powered_reg, powered_next;
    logic [4:0] cause_reg, cause_next;
    logic [31:0] periph_prev_reg, periph_prev_next;
    logic [31:0] periph_pulse_reg, periph_pulse_next;
    logic [31:0] wdog_count_reg, wdog_count_next;
    logic wdog_int_reg, wdog_int_next;
    logic wdog_fire_reg, wdog_fire_next;
    logic [3:0] rel_count_reg, rel_count_next;
    logic boot_reg, boot_next;
    reset_ctrl_pkg::seq_state_type state_reg, state_next;

    logic por_src, pin_src, droop_src, sw_src, wd_src, any_src;

    // droop seen while detection is switched on
    function automatic logic droop_seen(
        input logic enable,
        input logic detect
    );
        return enable && detect;
    endfunction : droop_seen

    // watchdog counter at its zero state
    function automatic logic count_at_zero(input logic [31:0] count);
        return count == 32'h00000000;
    endfunction : count_at_zero

    // the power-on source only counts until the first release
    assign por_src = power_on_detect && !powered_reg;
    assign pin_src = !reset_pin_n;
    assign droop_src = droop_seen(droop_detect_enable, supply_droop_detect)
        && droop_reset_enable;
    assign sw_src = system_reset_request_bit;
    assign wd_src = wdog_fire_reg;
    assign any_src = por_src | pin_src | droop_src | sw_src | wd_src;

    // droop with reset disabled goes to the processor as an interrupt
    assign droop_interrupt = droop_seen(droop_detect_enable,
        supply_droop_detect) && !droop_reset_enable;

    // combinational assert, clocked release
    assign core_reset = any_src
        || (state_reg != reset_ctrl_pkg::SEQ_RUN);
    assign periph_reset = core_reset;
    assign tap_reset = por_src || srst;
    assign wdog_interrupt = wdog_int_reg;
    assign reset_cause_record = cause_reg;
    assign boot_fetch = boot_reg;

    // each unit's software reset drives every domain of that unit
    generate
        for (genvar d = 0; d < reset_ctrl_pkg::DOMAINS; d++) begin : g_dom
            logic [31:0] dom_rst;
            assign dom_rst = periph_pulse_reg | {32{periph_reset}};
            if (d == 0) begin : g_d0
                assign periph_domain_reset_0 = dom_rst;
            end else begin : g_d1
                assign periph_domain_reset_1 = dom_rst;
            end
        end
    endgenerate

    // release sequencer
    always_comb begin
        state_next = state_reg;
        rel_count_next = rel_count_reg;
        boot_next = 1'b0;
        powered_next = powered_reg;
        case (state_reg)
            reset_ctrl_pkg::SEQ_HOLD: begin
                rel_count_next = 4'h0;
                if (!any_src) begin
                    state_next = reset_ctrl_pkg::SEQ_RELEASE;
                end
            end
            reset_ctrl_pkg::SEQ_RELEASE: begin
                if (any_src) begin
                    state_next = reset_ctrl_pkg::SEQ_HOLD;
                end else if (rel_count_reg == reset_ctrl_pkg::RELEASE_COUNT
                        - 4'h1) begin
                    state_next = reset_ctrl_pkg::SEQ_RUN;
                    boot_next = 1'b1;
                    powered_next = 1'b1;
                end else begin
                    rel_count_next = rel_count_reg + 4'h1;
                end
            end
            reset_ctrl_pkg::SEQ_RUN: begin
                if (any_src) begin
                    state_next = reset_ctrl_pkg::SEQ_HOLD;
                end
            end
            default: state_next = reset_ctrl_pkg::SEQ_HOLD;
        endcase
    end

    // cause record, sticky across resets
    always_comb begin
        cause_next = cause_reg;
        if (por_src) begin
            cause_next = 5'h00;
            cause_next[reset_ctrl_pkg::CAUSE_POWER_ON] = 1'b1;
        end else begin
            if (pin_src) begin
                cause_next[reset_ctrl_pkg::CAUSE_PIN] = 1'b1;
            end
            if (droop_src) begin
                cause_next[reset_ctrl_pkg::CAUSE_DROOP] = 1'b1;
            end
            if (sw_src) begin
                cause_next[reset_ctrl_pkg::CAUSE_SOFTWARE] = 1'b1;
            end
            if (wd_src) begin
                cause_next[reset_ctrl_pkg::CAUSE_WATCHDOG] = 1'b1;
            end
        end
    end

    // peripheral reset on a falling control bit, same positions as gating
    always_comb begin
        periph_prev_next = peripheral_reset_control_regs;
        periph_pulse_next = periph_prev_reg
            & ~peripheral_reset_control_regs;
    end

    // watchdog two-stage time-out
    always_comb begin
        wdog_count_next = wdog_count_reg;
        wdog_int_next = wdog_int_reg;
        wdog_fire_next = 1'b0;
        if (core_reset) begin
            wdog_count_next = watchdog_reload_value_reg;
            wdog_int_next = 1'b0;
        end else if (wdog_enable) begin
            if (wdog_service) begin
                wdog_count_next = watchdog_reload_value_reg;
            end else if (count_at_zero(wdog_count_reg)) begin
                wdog_count_next = watchdog_reload_value_reg;
                if (wdog_int_reg && wdog_reset_enable) begin
                    wdog_fire_next = 1'b1;
                end
                wdog_int_next = 1'b1;
            end else begin
                wdog_count_next = wdog_count_reg - 32'h00000001;
            end
            // a new time-out wins over a clear in the same cycle
            if (wdog_int_clear && !(count_at_zero(wdog_count_reg)
                    && !wdog_service)) begin
                wdog_int_next = 1'b0;
            end
        end else if (wdog_int_clear) begin
            wdog_int_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= reset_ctrl_pkg::SEQ_HOLD;
            rel_count_reg <= 4'h0;
            boot_reg <= 1'b0;
            powered_reg <= 1'b0;
            cause_reg <= reset_ctrl_pkg::CAUSE_RESET;
            periph_prev_reg <= 32'h00000000;
            periph_pulse_reg <= 32'h00000000;
            wdog_count_reg <= reset_ctrl_pkg::WDOG_COUNT_RESET;
            wdog_int_reg <= 1'b0;
            wdog_fire_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rel_count_reg <= rel_count_next;
            boot_reg <= boot_next;
            powered_reg <= powered_next;
            cause_reg <= cause_next;
            periph_prev_reg <= periph_prev_next;
            periph_pulse_reg <= periph_pulse_next;
            wdog_count_reg <= wdog_count_next;
            wdog_int_reg <= wdog_int_next;
            wdog_fire_reg <= wdog_fire_next;
        end
    end

    // checker helper: cycles since a source was last seen
    logic [3:0] quiet_reg, quiet_next;
    always_comb begin
        quiet_next = quiet_reg;
        if (any_src) begin
            quiet_next = 4'h0;
        end else if (quiet_reg != 4'hF) begin
            quiet_next = quiet_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            quiet_reg <= 4'h0;
        end else begin
            quiet_reg <= quiet_next;
        end
    end

    // checks
    a_release_wait: assert property (@(posedge core_clk) disable iff (srst)
        quiet_reg <= reset_ctrl_pkg::RELEASE_COUNT |-> core_reset)
        else $error("reset released too early");
    a_release_run: assert property (@(posedge core_clk) disable iff (srst)
        quiet_reg == reset_ctrl_pkg::RELEASE_COUNT + 4'h1
        |-> boot_fetch)
        else $error("reset not released after hold");
    a_hold_por: assert property (@(posedge core_clk) disable iff (srst)
        por_src |=> core_reset)
        else $error("power-on hold lost");
    a_boot_pulse: assert property (@(posedge core_clk) disable iff (srst)
        boot_fetch |=> !boot_fetch)
        else $error("boot fetch longer than one cycle");
    a_tap_scope: assert property (@(posedge core_clk) disable iff (srst)
        !por_src |-> !tap_reset)
        else $error("test port reset without power-on");
    a_droop_int_only: assert property (@(posedge core_clk) disable iff (srst)
        droop_interrupt |-> !droop_src)
        else $error("droop gave both interrupt and reset");
    a_droop_scope: assert property (@(posedge core_clk) disable iff (srst)
        droop_src |-> core_reset && periph_reset
            && (tap_reset == por_src))
        else $error("droop reset scope wrong");
    a_sw_reset: assert property (@(posedge core_clk) disable iff (srst)
        sw_src |-> core_reset && periph_reset)
        else $error("system request did not reset");
    a_periph_scope: assert property (@(posedge core_clk) disable iff (srst)
        periph_reset |-> (&periph_domain_reset_0)
            && (&periph_domain_reset_1))
        else $error("peripheral domain missed system reset");
    a_wdog_first: assert property (@(posedge core_clk) disable iff (srst)
        !core_reset && wdog_enable && !wdog_service
        && count_at_zero(wdog_count_reg) |=> wdog_interrupt)
        else $error("first time-out gave no interrupt");
    a_wdog_reload: assert property (@(posedge core_clk) disable iff (srst)
        !core_reset && wdog_enable && !wdog_service
        && count_at_zero(wdog_count_reg)
        |=> wdog_count_reg == $past(watchdog_reload_value_reg))
        else $error("counter not reloaded after time-out");
    a_wdog_int_hold: assert property (@(posedge core_clk) disable iff (srst)
        wdog_interrupt && !core_reset && !wdog_int_clear
        |=> wdog_interrupt)
        else $error("watchdog interrupt lost uncleared");
    a_por_cause: assert property (@(posedge core_clk) disable iff (srst)
        por_src |=> reset_cause_record
            == 5'(1 << reset_ctrl_pkg::CAUSE_POWER_ON))
        else $error("power-on cause not exclusive");
    a_pin_cause: assert property (@(posedge core_clk) disable iff (srst)
        pin_src && !por_src
        |=> reset_cause_record[reset_ctrl_pkg::CAUSE_PIN])
        else $error("pin cause not recorded");
    a_sw_cause: assert property (@(posedge core_clk) disable iff (srst)
        sw_src && !por_src
        |=> reset_cause_record[reset_ctrl_pkg::CAUSE_SOFTWARE])
        else $error("software cause not recorded");
    a_wd_cause: assert property (@(posedge core_clk) disable iff (srst)
        wd_src && !por_src
        |=> reset_cause_record[reset_ctrl_pkg::CAUSE_WATCHDOG])
        else $error("watchdog cause not recorded");
    a_por_tap_reset: assert property (@(posedge core_clk) disable iff (srst)
        por_src |-> tap_reset && core_reset)
        else $error("power-on did not reset test port");
    a_pin_no_tap: assert property (@(posedge core_clk) disable iff (srst)
        pin_src && !por_src |-> core_reset && !tap_reset)
        else $error("pin reset scope wrong");
    a_por_once: assert property (@(posedge core_clk) disable iff (srst)
        powered_reg |=> powered_reg && !por_src)
        else $error("power-on source retriggered");
    a_droop_gate: assert property (@(posedge core_clk) disable iff (srst)
        !droop_detect_enable |-> !droop_src && !droop_interrupt)
        else $error("droop active while disabled");
    a_droop_cause: assert property (@(posedge core_clk) disable iff (srst)
        droop_src && !por_src
        |=> cause_reg[reset_ctrl_pkg::CAUSE_DROOP])
        else $error("droop cause not recorded");
    a_cause_sticky: assert property (@(posedge core_clk) disable iff (srst)
        !por_src && !$past(srst) |=> (cause_reg & $past(cause_reg))
            == $past(cause_reg))
        else $error("cause bit lost");
    a_periph_pulse: assert property (@(posedge core_clk) disable iff (srst)
        $fell(peripheral_reset_control_regs[0]) |=>
            periph_domain_reset_0[0] && periph_domain_reset_1[0])
        else $error("peripheral reset pulse missing");
    a_wdog_second: assert property (@(posedge core_clk) disable iff (srst)
        !core_reset && wdog_enable && !wdog_service && wdog_int_reg
        && wdog_reset_enable && wdog_count_reg == 32'h00000000
        |=> core_reset ##1 core_reset)
        else $error("second time-out did not reset");
    a_release_boot: assert property (@(posedge core_clk) disable iff (srst)
        $fell(core_reset) |-> boot_fetch)
        else $error("release without boot fetch");
    c_pin_reset: cover property (@(posedge core_clk) $rose(pin_src));
    c_wdog_reset: cover property (@(posedge core_clk) wd_src);
    c_droop_int: cover property (@(posedge core_clk) droop_interrupt);
    c_boot: cover property (@(posedge core_clk) boot_fetch);
    c_droop_reset: cover property (@(posedge core_clk) droop_src);
endmodule : system_reset_controller

// *** logic/reset_ctrl_pkg.sv ***
package reset_ctrl_pkg;
    // width of the peripheral reset / clock gating word
    localparam int PERIPH_WIDTH = 32;
    // clock domains per peripheral unit
    localparam int DOMAINS = 2;
    // cause bit positions
    localparam int CAUSE_PIN = 0;
    localparam int CAUSE_POWER_ON = 1;
    localparam int CAUSE_DROOP = 2;
    localparam int CAUSE_SOFTWARE = 3;
    localparam int CAUSE_WATCHDOG = 4;
    localparam int CAUSE_WIDTH = 5;
    localparam logic [4:0] CAUSE_RESET = 5'h00;
    localparam logic [31:0] WDOG_COUNT_RESET = 32'hFFFFFFFF;
    // release stretch: time in ns and derived cycles at 125 MHz
    localparam int RELEASE_NS = 64;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RELEASE_CYCLES = (RELEASE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [3:0] RELEASE_COUNT = 4'(RELEASE_CYCLES);
    typedef enum logic [2:0] {
        SEQ_HOLD = 3'h1,
        SEQ_RELEASE = 3'h2,
        SEQ_RUN = 3'h4
    } seq_state_type;
endpackage : reset_ctrl_pkg

// *** tb/reset_pin_driver.sv ***
module reset_pin_driver #(
    parameter int MIN_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic pulse_req,
    output logic reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int count_reg = 0;
    // low for the full minimum pulse, pull-up level once released
    always @(posedge core_clk) begin
        if (pulse_req) begin
            count_reg <= MIN_CYCLES;
        end else if (count_reg != 0) begin
            count_reg <= count_reg - 1;
        end
    end
    assign reset_pin_n = (count_reg == 0);
endmodule : reset_pin_driver

// *** tb/test_system_reset_controller.sv ***
module test_system_reset_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, srst = 1'b1, pod = 1'b1, droop = 1'b0;
    logic droop_en = 1'b0, droop_rst = 1'b0, sysreq = 1'b0, pulse_req = 1'b0;
    logic wd_en = 1'b0, wd_rst = 1'b0, service = 1'b0, clr = 1'b0;
    logic [31:0] periph = 32'h0, reload = 32'h0, dom0, dom1;
    logic reset_pin_n, core_reset, periph_reset, tap_reset, droop_int;
    logic wdog_int, boot_fetch;
    logic [4:0] cause, watch;
    int n_mismatch = 0, tests_run = 0, n;
    assign watch = {|dom0, core_reset, wdog_int, reset_pin_n, boot_fetch};

    reset_pin_driver reset_pin_driver_inst (.core_clk(core_clk),
        .pulse_req(pulse_req), .reset_pin_n(reset_pin_n));
    system_reset_controller system_reset_controller_inst (
        .core_clk(core_clk), .srst(srst), .power_on_detect(pod),
        .reset_pin_n(reset_pin_n), .supply_droop_detect(droop),
        .droop_detect_enable(droop_en), .droop_reset_enable(droop_rst),
        .system_reset_request_bit(sysreq),
        .peripheral_reset_control_regs(periph), .wdog_enable(wd_en),
        .wdog_reset_enable(wd_rst), .watchdog_reload_value_reg(reload),
        .wdog_service(service), .wdog_int_clear(clr),
        .core_reset(core_reset), .periph_reset(periph_reset),
        .tap_reset(tap_reset), .periph_domain_reset_0(dom0),
        .periph_domain_reset_1(dom1), .droop_interrupt(droop_int),
        .wdog_interrupt(wdog_int), .reset_cause_record(cause),
        .boot_fetch(boot_fetch));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task results;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task step;
        @(posedge core_clk);
        #1;
    endtask : step

    // edges until the watched signal is high, bounded
    task wait_sig(input int which, input int limit, output int cnt);
        for (cnt = 1; cnt <= limit; cnt++) begin
            step;
            if (watch[which] === 1'b1) begin
                return;
            end
        end
        n_mismatch++;
        results;
    endtask : wait_sig

    initial begin
        repeat (12) step;
        check(core_reset, 1'b1);
        check(tap_reset, 1'b1);
        @(posedge core_clk) srst <= 1'b0;
        @(posedge core_clk) pod <= 1'b0;
        wait_sig(0, 40, n);
        check(n, 9);
        check(cause, 5'h02);
        @(posedge core_clk) pod <= 1'b1;
        repeat (3) step;
        check(core_reset, 1'b0);
        check(tap_reset, 1'b0);
        @(posedge core_clk) pod <= 1'b0;
        @(posedge core_clk) pulse_req <= 1'b1;
        @(posedge core_clk) pulse_req <= 1'b0;
        step;
        check({core_reset, periph_reset, tap_reset}, 3'h6);
        wait_sig(1, 20, n);
        wait_sig(0, 40, n);
        check(n, 9);
        check(cause, 5'h03);
        @(posedge core_clk) droop <= 1'b1;
        repeat (2) step;
        check({core_reset, droop_int}, 2'h0);
        @(posedge core_clk) droop_en <= 1'b1;
        step;
        check({core_reset, droop_int}, 2'h1);
        @(posedge core_clk) droop_rst <= 1'b1;
        repeat (4) step;
        check({core_reset, periph_reset, tap_reset}, 3'h6);
        @(posedge core_clk) droop <= 1'b0;
        wait_sig(0, 40, n);
        check(n, 9);
        check(cause, 5'h07);
        @(posedge core_clk) sysreq <= 1'b1;
        step;
        check({core_reset, periph_reset, tap_reset}, 3'h6);
        @(posedge core_clk) sysreq <= 1'b0;
        wait_sig(0, 40, n);
        check(n, 9);
        check(cause, 5'h0F);
        @(posedge core_clk) periph <= 32'h21;
        repeat (2) step;
        check(dom0 | dom1, 32'h0);
        @(posedge core_clk) periph <= 32'h0;
        wait_sig(4, 4, n);
        check(dom0, 32'h21);
        check(dom1, 32'h21);
        check(core_reset, 1'b0);
        step;
        check(dom0 | dom1, 32'h0);
        @(posedge core_clk) begin
            reload <= 32'h20;
            wd_en <= 1'b1;
            wd_rst <= 1'b1;
            service <= 1'b1;
        end
        @(posedge core_clk) service <= 1'b0;
        wait_sig(2, 80, n);
        check(n, 33);
        check(core_reset, 1'b0);
        wait_sig(3, 80, n);
        check(n, 33);
        @(posedge core_clk) wd_en <= 1'b0;
        wait_sig(0, 40, n);
        check({core_reset, cause}, 6'h1F);
        results;
    end
endmodule : test_system_reset_controller
